/* File: rtl/swl_link.v */
`timescale 1ns/1ps
`default_nettype none
`include "swl_regs.vh"

// What this block does
// - Bit period lies within 10 to 100 us
// - Accept periods from 0.8 to 1.2 times
// - Return to idle 220 us after rising
// - Slave takeover low pulse lasts 1-5 us
// - Long high is one, short high zero
// - Handover and takeover bits frame read data
// - Most significant byte travels first
module swl_link (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        ce,
   input  wire        lineIn,
   input  wire        txLoad,
   input  wire [15:0] txWord,
   output reg         lineOut_q,
   output reg         lineOe_n_q,
   output reg         rxBit_q,
   output reg         rxValid_q,
   output reg         frameActive_q,
   output reg         startSeen_q,
   output reg         timeoutEvt_q,
   output reg         periodErr_q,
   output reg         txBusy_q,
   output reg         txDone_q
);

   // One-hot receiver states
   localparam [2:0] ST_IDLE  = 3'h1;
   localparam [2:0] ST_FRAME = 3'h2;
   localparam [2:0] ST_TX    = 3'h4;

   localparam [6:0]  START_CYC = `SWL_START_CYC;
   localparam [11:0] TO_CYC    = `SWL_TO_CYC;
   localparam [11:0] PER_MIN   = `SWL_PER_MIN_CYC;
   localparam [11:0] PER_MAX   = `SWL_PER_MAX_CYC;
   localparam [2:0]  TOL_LO    = `SWL_TOL_LO;
   localparam [2:0]  TOL_HI    = `SWL_TOL_HI;
   localparam [2:0]  TOL_DEN   = `SWL_TOL_DEN;
   localparam [1:0]  SKIP_N    = `SWL_SKIP_RISES;
   localparam [11:0] CNT_SAT   = 12'hFFF;

   reg  [2:0]  st_q;        // Receiver state
   reg         lineHist_q;  // Previous line sample for edge detection
   reg  [6:0]  lowCnt_q;    // Low time while idle, saturating
   reg  [11:0] sinceRise_q; // Cycles since the last rising edge
   reg  [11:0] width_q;     // High width captured at the falling edge
   reg  [11:0] refPer_q;    // Reference bit period
   reg         haveRef_q;   // Reference period is valid
   reg         pending_q;   // A bit is open, waiting for its end
   reg  [1:0]  skip_q;      // Rising edges still to ignore after sending
   wire        rise;        // Line went high
   wire        fall;        // Line went low
   wire        bitOne;      // Decoded value of the closing bit
   wire        perOk;       // Closing period is acceptable
   wire        txDrive;     // Shaper wants the line low
   wire        txBusy;      // Shaper running
   wire        txDone;      // Shaper finished its word

   assign rise = lineIn & ~lineHist_q;
   assign fall = ~lineIn & lineHist_q;

   // Scaled ratio test: tol * ref against den * p, widened to 15 bits
   function ratioOk;
      input [11:0] per;
      input [11:0] refp;
      reg   [14:0] scaledPer;
      reg   [14:0] lowBound;
      reg   [14:0] highBound;
      begin
         scaledPer = {3'b000, per} * {12'h000, TOL_DEN};
         lowBound  = {3'b000, refp} * {12'h000, TOL_LO};
         highBound = {3'b000, refp} * {12'h000, TOL_HI};
         ratioOk   = (scaledPer >= lowBound) && (scaledPer <= highBound);
      end
   endfunction

   // Period within the absolute band and near the reference
   function periodOk;
      input [11:0] per;
      input [11:0] refp;
      input        hasRef;
      begin
         periodOk = (per >= PER_MIN) && (per <= PER_MAX) &&
                    (!hasRef || ratioOk(per, refp));
      end
   endfunction

   // Width over half the period reads as one
   assign bitOne = ({width_q, 1'b0} > {1'b0, sinceRise_q});
   assign perOk  = periodOk(sinceRise_q, refPer_q, haveRef_q);

   // Answer word shaper
   swl_bit_tx u_tx (
      .clk        (clk),
      .rst_n      (rst_n),
      .ce         (ce),
      .load       (txLoad && st_q == ST_FRAME && haveRef_q),
      .word       (txWord),
      .period     (refPer_q),
      .driveLow_q (txDrive),
      .busy_q     (txBusy),
      .done_q     (txDone)
   );

   // Pin drivers: open drain, enable low while pulling the line down
   always @(posedge clk) begin
      if (!rst_n) begin
         lineOut_q  <= 1'b0;
         lineOe_n_q <= 1'b1;
         txBusy_q   <= 1'b0;
         txDone_q   <= 1'b0;
      end else if (ce) begin
         lineOut_q  <= 1'b0;
         lineOe_n_q <= ~txDrive;
         txBusy_q   <= txBusy;
         txDone_q   <= txDone;
      end
   end

   // Edge history
   always @(posedge clk) begin
      if (!rst_n) begin
         lineHist_q <= 1'b1;
      end else if (ce) begin
         lineHist_q <= lineIn;
      end
   end

   // Receiver state machine and bit timing
   always @(posedge clk) begin
      if (!rst_n) begin
         st_q          <= ST_IDLE;
         lowCnt_q      <= 7'h00;
         sinceRise_q   <= 12'h000;
         width_q       <= 12'h000;
         refPer_q      <= 12'h000;
         haveRef_q     <= 1'b0;
         pending_q     <= 1'b0;
         skip_q        <= 2'h0;
         rxBit_q       <= 1'b0;
         rxValid_q     <= 1'b0;
         frameActive_q <= 1'b0;
         startSeen_q   <= 1'b0;
         timeoutEvt_q  <= 1'b0;
         periodErr_q   <= 1'b0;
      end else if (ce) begin
         // Event outputs last one cycle
         rxValid_q    <= 1'b0;
         startSeen_q  <= 1'b0;
         timeoutEvt_q <= 1'b0;
         periodErr_q  <= 1'b0;
         // Saturating count since the last rising edge, held at zero while sending
         if (sinceRise_q != CNT_SAT) begin
            sinceRise_q <= sinceRise_q + 12'h001;
         end
         case (st_q)
            ST_IDLE: begin
               // Measure low time; enough low then rising opens a frame
               if (lineIn) begin
                  lowCnt_q <= 7'h00;
               end else if (lowCnt_q != 7'h7F) begin
                  lowCnt_q <= lowCnt_q + 7'h01;
               end
               if (rise && lowCnt_q >= START_CYC) begin
                  st_q          <= ST_FRAME;
                  frameActive_q <= 1'b1;
                  startSeen_q   <= 1'b1;
                  sinceRise_q   <= 12'h001;
                  pending_q     <= 1'b1;
                  haveRef_q     <= 1'b0;
                  skip_q        <= 2'h0;
               end
            end
            ST_FRAME: begin
               if (fall) begin
                  // High part of the open bit ends here
                  width_q <= sinceRise_q;
               end
               if (rise) begin
                  // Count from one so a full period reads as its cycle count
                  sinceRise_q <= 12'h001;
                  if (skip_q != 2'h0) begin
                     // Own release or master takeover: restart timing
                     skip_q    <= skip_q - 2'h1;
                     pending_q <= 1'b1;
                  end else if (pending_q) begin
                     // Rising edge closes a bit and opens the next
                     if (perOk) begin
                        rxBit_q   <= bitOne;
                        rxValid_q <= 1'b1;
                        refPer_q  <= sinceRise_q;
                        haveRef_q <= 1'b1;
                     end else begin
                        periodErr_q <= 1'b1;
                     end
                  end
               end else if (sinceRise_q >= TO_CYC - 12'h001) begin
                  // No rising edge for too long: drop the frame; the
                  // closing high time also ends here
                  st_q          <= ST_IDLE;
                  frameActive_q <= 1'b0;
                  timeoutEvt_q  <= 1'b1;
                  pending_q     <= 1'b0;
                  lowCnt_q      <= 7'h00;
               end
               if (txLoad && haveRef_q) begin
                  // Slave answers after the master's handover bit
                  st_q <= ST_TX;
               end
            end
            ST_TX: begin
               // Own pulses on the line are not decoded
               sinceRise_q <= 12'h000;
               if (txDone) begin
                  st_q      <= ST_FRAME;
                  skip_q    <= SKIP_N;
                  pending_q <= 1'b0;
               end
            end
            default: begin
               st_q          <= ST_IDLE;
               frameActive_q <= 1'b0;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

/* File: rtl/swl_regs.vh */
`ifndef SWL_REGS_VH
`define SWL_REGS_VH

// Clock rate in MHz (100 ns period)
`define SWL_CLK_MHZ      10

// Least low time before the opening rising edge, in us
`define SWL_START_US     5
`define SWL_START_CYC    (`SWL_START_US * `SWL_CLK_MHZ)

// Least high time of the closing condition, in us
`define SWL_STOP_US      5

// Bit period limits, in us
`define SWL_TBIT_MIN_US  10
`define SWL_TBIT_MAX_US  100

// Accepted period band after the 0.8 / 1.2 tolerance, in cycles
`define SWL_PER_MIN_CYC  ((`SWL_TBIT_MIN_US * `SWL_CLK_MHZ * 4) / 5)
`define SWL_PER_MAX_CYC  ((`SWL_TBIT_MAX_US * `SWL_CLK_MHZ * 6) / 5)

// Tolerance ratio as numerator pair over a denominator of five
`define SWL_TOL_LO       4
`define SWL_TOL_HI       6
`define SWL_TOL_DEN      5

// Inactivity timeout, in us, rounded down to cycles
`define SWL_TO_US        220
`define SWL_TO_CYC       (`SWL_TO_US * `SWL_CLK_MHZ)

// Slave takeover low pulse, in us; legal window is 1 to 5 us
`define SWL_TKO_US       3
`define SWL_TKO_CYC      (`SWL_TKO_US * `SWL_CLK_MHZ)

// Bits in one slave answer word
`define SWL_WORD_BITS    16

// Rising edges ignored after the slave hands the line back
`define SWL_SKIP_RISES   2

`endif

/* File: rtl/swl_bit_tx.v */
`timescale 1ns/1ps
`default_nettype none
`include "swl_regs.vh"

// Slave-side shaper: takeover pulse, then one word in pulse-width code
module swl_bit_tx (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        ce,
   input  wire        load,
   input  wire [15:0] word,
   input  wire [11:0] period,
   output reg         driveLow_q,
   output reg         busy_q,
   output reg         done_q
);

   // One-hot shaper states
   localparam [3:0] S_IDLE = 4'h1;
   localparam [3:0] S_TKO  = 4'h2;
   localparam [3:0] S_HIGH = 4'h4;
   localparam [3:0] S_LOW  = 4'h8;
   localparam [11:0] TKO_CYC  = `SWL_TKO_CYC;
   localparam [4:0]  LAST_BIT = `SWL_WORD_BITS - 1;

   reg [3:0]  st_q;      // Current state
   reg [11:0] cnt_q;     // Cycles left in the current phase
   reg [15:0] shift_q;   // Word being sent, current bit on top
   reg [4:0]  bitIdx_q;  // Index of the bit being sent

   // High time of a bit: three quarters for one, one quarter for zero
   function [11:0] highLen;
      input        bitVal;
      input [11:0] per;
      begin
         highLen = bitVal ? (per - {2'b00, per[11:2]}) : {2'b00, per[11:2]};
      end
   endfunction

   // Phase sequencer
   always @(posedge clk) begin
      if (!rst_n) begin
         st_q       <= S_IDLE;
         cnt_q      <= 12'h000;
         shift_q    <= 16'h0000;
         bitIdx_q   <= 5'h00;
         driveLow_q <= 1'b0;
         busy_q     <= 1'b0;
         done_q     <= 1'b0;
      end else if (ce) begin
         done_q <= 1'b0;
         case (st_q)
            S_IDLE: begin
               // Take the line with a short low pulse
               if (load) begin
                  shift_q    <= word;
                  bitIdx_q   <= 5'h00;
                  cnt_q      <= TKO_CYC - 12'h001;
                  driveLow_q <= 1'b1;
                  busy_q     <= 1'b1;
                  st_q       <= S_TKO;
               end
            end
            S_TKO: begin
               // Release ends the takeover and opens the first bit
               if (cnt_q == 12'h000) begin
                  driveLow_q <= 1'b0;
                  cnt_q      <= highLen(shift_q[15], period) - 12'h001;
                  st_q       <= S_HIGH;
               end else begin
                  cnt_q <= cnt_q - 12'h001;
               end
            end
            S_HIGH: begin
               // High phase done, pull low for the rest of the period
               if (cnt_q == 12'h000) begin
                  driveLow_q <= 1'b1;
                  cnt_q      <= period - highLen(shift_q[15], period) - 12'h001;
                  st_q       <= S_LOW;
               end else begin
                  cnt_q <= cnt_q - 12'h001;
               end
            end
            S_LOW: begin
               if (cnt_q == 12'h000) begin
                  driveLow_q <= 1'b0;
                  if (bitIdx_q == LAST_BIT) begin
                     // Hand the line back for the master's takeover bit
                     busy_q <= 1'b0;
                     done_q <= 1'b1;
                     st_q   <= S_IDLE;
                  end else begin
                     // Next bit, most significant first
                     shift_q  <= {shift_q[14:0], 1'b0};
                     bitIdx_q <= bitIdx_q + 5'h01;
                     cnt_q    <= highLen(shift_q[14], period) - 12'h001;
                     st_q     <= S_HIGH;
                  end
               end else begin
                  cnt_q <= cnt_q - 12'h001;
               end
            end
            default: begin
               st_q       <= S_IDLE;
               driveLow_q <= 1'b0;
               busy_q     <= 1'b0;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

/* File: verif/swl_link_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
`include "swl_regs.vh"
// Port checks on the link
module swl_link_asserts (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic lineIn,
   input wire logic txLoad,
   input wire logic lineOut_q,
   input wire logic lineOe_n_q,
   input wire logic rxBit_q,
   input wire logic rxValid_q,
   input wire logic frameActive_q,
   input wire logic startSeen_q,
   input wire logic txBusy_q
);
   logic [11:0] lowCnt_q, gap_q, per_q, hiCnt_q, hiW_q, oeLow_q, quiet_q; // Run counters
   logic        prev_q, gotBit_q, first_q; // Line history, answer flags
   wire rise = lineIn & ~prev_q; // Line rising edge
   wire loadOk = txLoad & frameActive_q & gotBit_q & ~txBusy_q & lineOe_n_q; // Answer taken
   // Measure periods, widths and silence
   always @(posedge clk) begin
      prev_q   <= rst_n ? lineIn : 1'b1;
      lowCnt_q <= lineIn ? 12'h000 : lowCnt_q + 12'h001;
      gap_q    <= rise ? 12'h001 : gap_q + 12'h001;
      per_q    <= rise ? gap_q : per_q;
      hiCnt_q  <= rise ? 12'h001 : hiCnt_q + {11'h000, lineIn};
      hiW_q    <= (prev_q & ~lineIn) ? hiCnt_q : hiW_q;
      oeLow_q  <= lineOe_n_q ? 12'h000 : oeLow_q + 12'h001;
      quiet_q  <= (rise | ~frameActive_q) ? 12'h000 : quiet_q + 12'h001;
      gotBit_q <= rst_n & frameActive_q & (gotBit_q | rxValid_q);
      first_q  <= rst_n & (loadOk | (first_q & ~(lineOe_n_q & (oeLow_q != 12'h000))));
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence sLoad;
      loadOk;
   endsequence
   sequence sHeld;
      !lineOe_n_q [*8];
   endsequence
   chk_data_low: assert property (lineOut_q == 1'b0)
      else $error("data not low");
   chk_start_seen: assert property (startSeen_q |-> frameActive_q && $past(lineIn)
      && !$past(lineIn, 2) && $past(lowCnt_q) >= 12'h032) else $error("bad start");
   chk_bit_edge: assert property (rxValid_q |-> $past(lineIn) && !$past(lineIn, 2))
      else $error("bit off edge");
   chk_bit_band: assert property (rxValid_q |-> per_q >= 12'h050 && per_q <= 12'h4B0)
      else $error("period out of band");
   chk_bit_value: assert property (rxValid_q |-> rxBit_q == (hiW_q * 2 > per_q))
      else $error("bit value");
   chk_take_start: assert property (sLoad |-> ##2 sHeld)
      else $error("no takeover");
   chk_take_width: assert property ($rose(lineOe_n_q) && first_q |->
      oeLow_q == `SWL_TKO_CYC) else $error("takeover width");
   chk_quiet_max: assert property (frameActive_q && !txBusy_q |-> quiet_q <= 12'h89A)
      else $error("no timeout");
endmodule
bind swl_link swl_link_asserts chk (
   .clk           (clk),
   .rst_n         (rst_n),
   .lineIn        (lineIn),
   .txLoad        (txLoad),
   .lineOut_q     (lineOut_q),
   .lineOe_n_q    (lineOe_n_q),
   .rxBit_q       (rxBit_q),
   .rxValid_q     (rxValid_q),
   .frameActive_q (frameActive_q),
   .startSeen_q   (startSeen_q),
   .txBusy_q      (txBusy_q)
);
`default_nettype wire

/* File: verif/swl_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Programmer side of the link; line has a pull-up
module swl_master_model (
   input  wire logic clk,
   input  wire logic lineWire,
   output var  logic pullLow
);
   initial pullLow = 1'b0;
   // Step just past the next clock edge
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   // Hold a level for n cycles
   task automatic hold(input logic lv, input int n);
      pullLow = ~lv;
      repeat (n) tick();
   endtask
   // Count cycles while the line keeps a level
   task automatic span(input logic lv, output int n);
      n = 0;
      while (lineWire === lv && n < 2000) begin
         tick();
         n++;
      end
   endtask
   // Opening low phase
   task automatic start();
      hold(1'b0, 60);
   endtask
   // Idle high while the pump settles, 1 ms at 10 MHz
   task automatic pumpWait();
      hold(1'b1, 10000);
   endtask
   // Program and command-entry waits span tens of ms, past this run's length
   // The master must still keep them
   // Closing high phase
   task automatic stop();
      hold(1'b1, 60);
   endtask
   // One bit in pulse-width code
   task automatic bitTx(input int per, input logic v);
      int w;
      w = v ? per - per / 4 : per / 4;
      hold(1'b1, w);
      hold(1'b0, per - w);
   endtask
   // Decode the answer word, first bit first
   task automatic readWord(input int per, output logic [15:0] w);
      int h;
      pullLow = 1'b0;
      span(1'b1, h);
      for (int i = 15; i >= 0; i--) begin
         span(1'b0, h);
         span(1'b1, h);
         w[i] = h * 2 > per;
      end
   endtask
endmodule
`default_nettype wire

/* File: verif/test_one_wire_programming_timing.sv */
`timescale 1ns/1ps
`default_nettype none
// Master model drives bits, bench model predicts decode
module test_one_wire_programming_timing;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        txLoad = 1'b0;
   logic        ce = 1'b1;
   logic [15:0] txWord = 16'h0000;
   logic [15:0] rdWord;
   logic [31:0] rng = 32'h8501F99A;
   logic [31:0] r;
   logic        pullLow;
   wire         oeN, rxBit, rxValid, active, pErr, busy, done, tmo;
   wire         lineIn = ~pullLow & (oeN !== 1'b0); // Pulled-up wire
   int          err_count = 0;
   int          check_count = 0;
   int          cyc = 0;
   int          refPer = 0;
   int          n, e;
   int          expQ[$];
   int          pers[10] = '{100, 80, 96, 115, 138, 111, 100, 60, 125, 100};
   swl_link dut (.clk(clk), .rst_n(rst_n), .ce(ce), .lineIn(lineIn), .txLoad(txLoad),
      .txWord(txWord), .lineOut_q(), .lineOe_n_q(oeN), .rxBit_q(rxBit), .rxValid_q(rxValid),
      .frameActive_q(active), .startSeen_q(), .timeoutEvt_q(tmo), .periodErr_q(pErr),
      .txBusy_q(busy), .txDone_q(done));
   swl_master_model master (.clk(clk), .lineWire(lineIn), .pullLow(pullLow));
   always #50 clk = ~clk;
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      if (err_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Queue the expected decode, then send a random bit
   task automatic sendBit(input int per);
      int v, bad;
      v = int'(rnd() & 32'h00000001);
      bad = per < 80 || per > 1200 || (refPer > 0 && (5 * per < 4 * refPer
         || 5 * per > 6 * refPer));
      expQ.push_back(bad ? 2 : v);
      if (!bad)
         refPer = per;
      master.bitTx(per, v[0]);
   endtask
   // Wait for the done pulse or the timeout pulse; n at the limit means never seen
   task automatic waitFor(input bit useTmo);
      n = 0;
      while ((useTmo ? tmo : done) !== 1'b1 && n < 2400) begin
         master.tick();
         n++;
      end
   endtask
   // Each decoded bit or period fault against the queue
   always @(posedge clk) begin
      #1;
      if (rxValid === 1'b1 || pErr === 1'b1) begin
         e = expQ.size() > 0 ? expQ.pop_front() : 3;
         check(pErr === 1'b1 ? 16'h0002 : {15'h0000, rxBit}, e[15:0]);
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         summarize();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      master.start();
      foreach (pers[i]) sendBit(pers[i]);
      master.hold(1'b1, 4);
      r = rnd();
      txWord = r[15:0];
      fork
         master.readWord(refPer, rdWord);
         begin
            txLoad = 1'b1;
            master.tick();
            txLoad = 1'b0;
         end
      join
      check(rdWord, txWord);
      waitFor(1'b0);
      check(16'(n < 300), 16'h0001);
      master.hold(1'b1, 2);
      master.hold(1'b0, 25);
      sendBit(100);
      sendBit(100);
      master.stop();
      waitFor(1'b1);
      check(16'(n < 2300), 16'h0001);
      master.tick();
      check({15'h0000, active}, 16'h0000);
      master.hold(1'b0, 20);
      master.hold(1'b1, 20);
      check({15'h0000, active}, 16'h0000);
      // Frozen by a low clock enable, a full start goes unseen
      ce = 1'b0;
      master.start();
      master.hold(1'b1, 4);
      ce = 1'b1;
      master.tick();
      check({15'h0000, active}, 16'h0000);
      master.pumpWait();
      // A new frame has no reference period yet
      refPer = 0;
      master.start();
      repeat (8) sendBit(95 + int'(rnd() % 16));
      master.stop();
      check({15'h0000, active}, 16'h0001);
      check(16'(expQ.size()), 16'h0000);
      summarize();
   end
endmodule
`default_nettype wire
